// *** lisas_consts.svh ***
// Named constants for the local/ISA address steering block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef LISAS_CONSTS_SVH
`define LISAS_CONSTS_SVH

// ---------------------------------------------------------------------------
// Synchroniser and field widths
// ---------------------------------------------------------------------------
`define LISAS_CTRL_W      9
`define LISAS_ADDR_W      31
`define LISAS_MID_W       7
`define LISAS_HI_W        5
`define LISAS_CLAIM_W     3
`define LISAS_LOAD_DLY    2

// ---------------------------------------------------------------------------
// Decode constants
// ---------------------------------------------------------------------------
`define LISAS_KBC_DATA    8'h18
`define LISAS_KBC_CMD     8'h19
`define LISAS_MID_ZERO    7'h00
`define LISAS_HI_LOW      5'h00
`define LISAS_BE_NONE     4'hF
`define LISAS_CLAIM_NONE  3'h0
`define LISAS_STATUS_IDLE 4'hF

`endif

// *** lisas_pkg.sv ***
// Types shared by the local/ISA address steering block.
// Assumes the constants header is compiled alongside.
package lisas_pkg;

  // -------------------------------------------------------------------------
  // Cycle owner, Gray coded along host to DMA to ISA master.
  // -------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LISAS_HOST = 2'h0,
    LISAS_DMA  = 2'h1,
    LISAS_ISAM = 2'h3
  } lisas_owner_e;

  // -------------------------------------------------------------------------
  // Bus state tracker for claim sampling, Gray coded.
  // -------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LISAS_IDLE = 2'h0,
    LISAS_T1   = 2'h1,
    LISAS_T2A  = 2'h3,
    LISAS_T2B  = 2'h2
  } lisas_tstate_e;

endpackage : lisas_pkg

// *** lisas_sync.sv ***
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/1ps

module lisas_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= '0;
      q_o      <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule : lisas_sync

// *** lisas_steering.sv ***
// Address-path steering between the local processor bus and the ISA bus.
// Assumes pins arrive asynchronously and the DMA engine drives the
// cycle_drive and dma_load inputs from this same clock.
//
// Contract
// R1: Byte enables are inputs for host accesses to ISA and driven for DMA and ISA master cycles.
// R2: Driven byte enables come from the buffered low address bits and the high-byte enable.
// R3: The high-byte enable is driven for host accesses and is an input for DMA or ISA master.
// R4: The buffered low address bits are driven for host accesses and inputs otherwise.
// R5: Address bits 2 to 9 and 17 to 23 are never driven, only received.
// R6: In DMA cycles address bits 10 to 16 are driven from a latch loaded off intermediate data.
// R7: In DMA and ISA master cycles bits 24 to 27 and 31 are driven low, else released.
// R8: The combined select is the OR of the boot ROM select and keyboard controller select.
// R9: The keyboard controller select fires only for I/O ports 60 and 64.
// R10: The boot ROM select decodes a range set by configuration.
// R11: A low claim input means its agent takes the cycle, for each of three claims.
// R12: Claims are sampled at the end of the first or the second T2, per configuration.
// R13: Only the first claim is honoured until the second and third are enabled.
// R14: Strobe and status lines are inputs for host cycles and driven in DMA and ISA master.
// R15: Hold acknowledge or local grant low means DMA or ISA master owns the cycle.
// R16: Any two-way line the device need not drive is released.
`timescale 1ns/1ps
`include "lisas_consts.svh"

module lisas_steering
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Arbitration pins
  input  wire logic        hold_ack_i,
  input  wire logic        local_grant_b_i,
  input  wire logic        isa_master_b_i,
  // Byte enables
  input  wire logic [3:0]  be_b_i,
  output logic      [3:0]  be_b_o,
  output logic             be_oe_b_o,
  // ISA high-byte enable
  input  wire logic        sbhe_b_i,
  output logic             sbhe_b_o,
  output logic             sbhe_oe_b_o,
  // Buffered low address
  input  wire logic [1:0]  buffered_low_address_i,
  output logic      [1:0]  buffered_low_address_o,
  output logic             buffered_low_address_oe_b_o,
  // Local address pins
  input  wire logic [7:0]  addr_2_9_i,
  input  wire logic [6:0]  addr_10_16_i,
  output logic      [6:0]  addr_10_16_o,
  output logic             addr_10_16_oe_b_o,
  input  wire logic [6:0]  addr_17_23_i,
  output logic      [4:0]  addr_hi_o,
  output logic             addr_hi_oe_b_o,
  // Strobe and status lines
  input  wire logic        ads_b_i,
  input  wire logic        m_io_i,
  input  wire logic [3:0]  cycle_drive_i,
  output logic      [3:0]  cycle_status_o,
  output logic             cycle_status_oe_b_o,
  // DMA page latch
  input  wire logic [6:0]  intermediate_data_low_i,
  input  wire logic        dma_load_i,
  // Chip select configuration and output
  input  wire logic        rom_enable_i,
  input  wire logic [6:0]  rom_base_i,
  input  wire logic [6:0]  rom_mask_i,
  output logic             rom_or_kbc_select_b_o,
  // Local device claims
  input  wire logic [2:0]  local_device_claim_b_i,
  input  wire logic [1:0]  claim_enable_i,
  input  wire logic        claim_second_t2_i,
  output logic      [2:0]  claimed_o,
  output logic             claim_valid_o
);

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  logic [`LISAS_CTRL_W-1:0] ctrl_s;
  logic [`LISAS_ADDR_W-1:0] addr_s;
  logic                     hlda_s;
  logic                     lgnt_b_s;
  logic                     master_b_s;
  logic [2:0]               claim_b_s;
  logic                     ads_b_s;
  logic                     m_io_s;
  logic                     sbhe_b_s;
  logic [1:0]               xa_s;
  logic [7:0]               a2_9_s;
  logic [6:0]               a10_16_s;
  logic [6:0]               a17_23_s;
  logic [6:0]               xd_s;

  lisas_sync #(.W(`LISAS_CTRL_W)) u_ctrl_sync
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     (~{hold_ack_i, local_grant_b_i, isa_master_b_i,
                local_device_claim_b_i, ads_b_i, m_io_i, sbhe_b_i}),
    .q_o     (ctrl_s)
  );

  lisas_sync #(.W(`LISAS_ADDR_W)) u_addr_sync
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     ({buffered_low_address_i, addr_2_9_i, addr_10_16_i,
                addr_17_23_i, intermediate_data_low_i}),
    .q_o     (addr_s)
  );

  // Unpack the synchronised vectors. Control pins travel inverted so that a
  // cleared synchroniser reads as their idle high level; otherwise the first
  // edges after reset would see a grant and a strobe that never happened.
  assign {hlda_s, lgnt_b_s, master_b_s, claim_b_s, ads_b_s, m_io_s, sbhe_b_s} = ~ctrl_s;
  assign {xa_s, a2_9_s, a10_16_s, a17_23_s, xd_s} = addr_s;

  // -------------------------------------------------------------------------
  // Cycle ownership
  // -------------------------------------------------------------------------
  lisas_pkg::lisas_owner_e owner_reg;
  lisas_pkg::lisas_owner_e owner_next;
  logic                    alt_owned;

  // Either handshake low hands the bus to DMA or an ISA master.
  always_comb
  begin
    if (!hlda_s || !lgnt_b_s)                                   // [R15]
      owner_next = master_b_s ? lisas_pkg::LISAS_DMA : lisas_pkg::LISAS_ISAM;
    else
      owner_next = lisas_pkg::LISAS_HOST;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      owner_reg <= lisas_pkg::LISAS_HOST;
    else
      owner_reg <= owner_next;
  end

  assign alt_owned = (owner_reg != lisas_pkg::LISAS_HOST);

  // -------------------------------------------------------------------------
  // Direction control
  // -------------------------------------------------------------------------
  // Enables are active low; lines not called for stay released. Address bits
  // 2 to 9 and 17 to 23 have no output path at all.                 [R5]
  assign be_oe_b_o                   = !alt_owned;              // [R1] [R16]
  assign sbhe_oe_b_o                 = alt_owned;               // [R3] [R16]
  assign buffered_low_address_oe_b_o = alt_owned;               // [R4] [R16]
  assign addr_10_16_oe_b_o           = (owner_reg != lisas_pkg::LISAS_DMA); // [R6]
  assign addr_hi_oe_b_o              = !alt_owned;              // [R7] [R16]
  assign cycle_status_oe_b_o         = !alt_owned;              // [R14]

  // -------------------------------------------------------------------------
  // Byte enables and low address outputs
  // -------------------------------------------------------------------------
  // In alternate cycles the word half comes from the upper buffered bit and
  // the pair inside it from the lower bit and the high-byte enable.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      be_b_o <= `LISAS_BE_NONE;
    else
      be_b_o <= xa_s[1] ? {sbhe_b_s, xa_s[0], 2'h3}            // [R2]
                        : {2'h3, sbhe_b_s, xa_s[0]};
  end

  // Host accesses: high-byte enable and low address follow the byte enables.
  // Byte enables are sampled directly here; they come from this clock's CPU.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sbhe_b_o               <= 1'h1;
      buffered_low_address_o <= 2'h0;
    end
    else
    begin
      sbhe_b_o                  <= be_b_i[1] & be_b_i[3];       // [R3]
      buffered_low_address_o[1] <= be_b_i[0] & be_b_i[1];       // [R4]
      buffered_low_address_o[0] <= !(be_b_i[0] == 1'h0 || (be_b_i[1:0] == 2'h3 &&
                                     be_b_i[2] == 1'h0));
    end
  end

  // -------------------------------------------------------------------------
  // DMA page latch and fixed upper address
  // -------------------------------------------------------------------------
  logic [`LISAS_LOAD_DLY-1:0] load_pipe_reg;

  // The load strobe is delayed to line up with the synchronised data.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      load_pipe_reg <= '0;
    else
      load_pipe_reg <= {load_pipe_reg[`LISAS_LOAD_DLY-2:0], dma_load_i};
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      addr_10_16_o <= `LISAS_MID_ZERO;
    else if (load_pipe_reg[`LISAS_LOAD_DLY-1])
      addr_10_16_o <= xd_s;                                     // [R6]
  end

  // The upper lines only ever drive zero when enabled.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      addr_hi_o <= `LISAS_HI_LOW;
    else
      addr_hi_o <= `LISAS_HI_LOW;                               // [R7]
  end

  // Strobe and status values come from the DMA engine of this clock.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cycle_status_o <= `LISAS_STATUS_IDLE;
    else
      cycle_status_o <= cycle_drive_i;                          // [R14]
  end

  // -------------------------------------------------------------------------
  // ROM and keyboard controller select
  // -------------------------------------------------------------------------
  logic kbc_hit;
  logic rom_hit;
  logic kbc_hit_reg;
  logic rom_hit_reg;

  // Ports 60 and 64 sit in dword 18 or 19 on lane 0 with the page bits zero.
  assign kbc_hit = !m_io_s && !be_b_i[0] && a10_16_s == `LISAS_MID_ZERO &&
                   (a2_9_s == `LISAS_KBC_DATA || a2_9_s == `LISAS_KBC_CMD); // [R9]
  assign rom_hit = m_io_s && rom_enable_i &&
                   ((a17_23_s & rom_mask_i) == (rom_base_i & rom_mask_i));  // [R10]

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      kbc_hit_reg <= 1'h0;
      rom_hit_reg <= 1'h0;
    end
    else
    begin
      kbc_hit_reg <= kbc_hit && !alt_owned;
      rom_hit_reg <= rom_hit && !alt_owned;
    end
  end

  assign rom_or_kbc_select_b_o = !(kbc_hit_reg || rom_hit_reg); // [R8]

  // -------------------------------------------------------------------------
  // Claim sampling
  // -------------------------------------------------------------------------
  lisas_pkg::lisas_tstate_e tstate_reg;
  logic                     sample_now;
  logic [2:0]               claim_mask;

  // A strobe in a host cycle starts T1; two T2 states follow at most.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tstate_reg <= lisas_pkg::LISAS_IDLE;
    else
    begin
      case (tstate_reg)
        lisas_pkg::LISAS_IDLE: tstate_reg <= (!ads_b_s && !alt_owned) ?
                                             lisas_pkg::LISAS_T1 : lisas_pkg::LISAS_IDLE;
        lisas_pkg::LISAS_T1:   tstate_reg <= lisas_pkg::LISAS_T2A;
        lisas_pkg::LISAS_T2A:  tstate_reg <= claim_second_t2_i ?
                                             lisas_pkg::LISAS_T2B : lisas_pkg::LISAS_IDLE;
        lisas_pkg::LISAS_T2B:  tstate_reg <= lisas_pkg::LISAS_IDLE;
        default:               tstate_reg <= lisas_pkg::LISAS_IDLE;
      endcase
    end
  end

  assign sample_now = (tstate_reg == lisas_pkg::LISAS_T2A && !claim_second_t2_i) ||
                      (tstate_reg == lisas_pkg::LISAS_T2B);     // [R12]
  assign claim_mask = {claim_enable_i, 1'h1};                   // [R13]

  // Enables reset low in the driving logic, so only claim 0 counts at power-up.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      claimed_o     <= `LISAS_CLAIM_NONE;
      claim_valid_o <= 1'h0;
    end
    else
    begin
      claim_valid_o <= sample_now;
      if (sample_now)
        claimed_o <= ~claim_b_s & claim_mask;                   // [R11] [R13]
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  a_owner_map: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R15]
    (!hlda_s || !lgnt_b_s) |=> alt_owned)
    else $error("Grant low did not hand the bus to an alternate owner.");
  a_be_drive: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R1]
    alt_owned == !be_oe_b_o)
    else $error("Byte enable direction wrong for owner.");
  a_be_derive: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R2]
    $past(rst_b_i) && ($past(xa_s) == 2'h0) |-> be_b_o[3:2] == 2'h3 && be_b_o[0] == 1'h0)
    else $error("Driven byte enables disagree with low address.");
  a_sbhe_xa_dir: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R3]
    alt_owned |-> sbhe_oe_b_o && buffered_low_address_oe_b_o)
    else $error("High-byte enable or low address driven in alternate cycle.");
  a_xa_host: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R4]
    $past(be_b_i) == 4'hB |-> buffered_low_address_o == 2'h2)
    else $error("Low address not derived from byte enable 2.");
  a_page_drive: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R6]
    load_pipe_reg[1] |=> addr_10_16_o == $past(xd_s))
    else $error("Page latch did not take intermediate data.");
  a_hi_low: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R7]
    !addr_hi_oe_b_o |-> addr_hi_o == `LISAS_HI_LOW && alt_owned)
    else $error("Upper address not low while driven.");
  a_kbc_port: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R9]
    kbc_hit_reg |-> $past(!m_io_s) && ($past(a2_9_s) == `LISAS_KBC_DATA ||
                                       $past(a2_9_s) == `LISAS_KBC_CMD))
    else $error("Keyboard select outside ports 60 and 64.");
  a_sel_or: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R8]
    $past(rst_b_i) && $past(rom_hit && !alt_owned) |-> !rom_or_kbc_select_b_o)
    else $error("ROM hit did not assert the combined select.");
  a_claim_time: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R12]
    (tstate_reg == lisas_pkg::LISAS_T1) ##1 claim_second_t2_i |=> ##1 claim_valid_o)
    else $error("Claim not sampled at the end of the second T2.");
  a_claim_mask: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R13]
    claim_valid_o && $past(claim_enable_i) == 2'h0 |-> claimed_o[2:1] == 2'h0)
    else $error("Disabled claim input was honoured.");
  a_claim_low: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R11]
    claim_valid_o |-> claimed_o[0] == !$past(claim_b_s[0]))
    else $error("Claim 0 not taken from a low input.");
  a_status_dir: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [R14]
    alt_owned == !cycle_status_oe_b_o)
    else $error("Status line direction wrong for owner.");

  c_dma_cycle: cover property (@(posedge clock_i) owner_reg == lisas_pkg::LISAS_DMA);
  c_isam_cycle: cover property (@(posedge clock_i) owner_reg == lisas_pkg::LISAS_ISAM);
  c_claim_seen: cover property (@(posedge clock_i) claim_valid_o && claimed_o[0]);
  c_kbc_sel: cover property (@(posedge clock_i) kbc_hit_reg);

endmodule : lisas_steering

// *** lisas_far_side.sv ***
// Far-side model of the processor bus masters and the ISA masters.
// Assumes the bench picks the cycle owner and the values that the far side drives.
`timescale 1ns/1ps

module lisas_far_side
(
  // Choices made by the bench
  input  wire logic [1:0] owner_i,
  input  wire logic [3:0] be_val_i,
  input  wire logic       sbhe_val_i,
  input  wire logic [1:0] xa_val_i,
  // Device side of the two-way lines
  input  wire logic [3:0] dev_be_i,
  input  wire logic       be_oe_b_i,
  input  wire logic       dev_sbhe_i,
  input  wire logic       sbhe_oe_b_i,
  input  wire logic [1:0] dev_xa_i,
  input  wire logic       xa_oe_b_i,
  // Arbitration levels and resolved wires
  output logic            hold_ack_o,
  output logic            local_grant_b_o,
  output logic            isa_master_b_o,
  output logic      [3:0] be_o,
  output logic            sbhe_o,
  output logic      [1:0] xa_o
);
  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  // Owner 1 is DMA through hold, owner 2 an ISA master through the grant.
  assign hold_ack_o      = (owner_i != 2'h1);
  assign local_grant_b_o = (owner_i != 2'h2);
  assign isa_master_b_o  = (owner_i != 2'h2);

  // ---------------------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------------------
  // The far side drives a line only while the device has let it go, so a
  // clash can never hide a direction fault behind a lucky value.
  assign be_o   = be_oe_b_i ? be_val_i : dev_be_i;
  assign sbhe_o = sbhe_oe_b_i ? sbhe_val_i : dev_sbhe_i;
  assign xa_o   = xa_oe_b_i ? xa_val_i : dev_xa_i;

endmodule : lisas_far_side

// *** lisas_steering_test.sv ***
// Self-checking bench for the local/ISA address steering block.
// Assumes the far-side model file is compiled before this one.
`timescale 1ns/1ps

module lisas_steering_test;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic       clock_i, rst_b_i, ads_b_i, m_io_i, dma_load_i, rom_enable_i;
  logic       claim_second_t2_i, sbhe_val, hold_ack, grant_b, isam_b, sbhe_w;
  logic       sbhe_b_o, be_oe_b_o, sbhe_oe_b_o, xa_oe_b_o, a10_oe_b, hi_oe_b;
  logic       status_oe_b, sel_b, claim_valid_o;
  logic [1:0] owner, xa_val, claim_enable_i, xa_w, xa_o;
  logic [2:0] claim_b, claimed_o;
  logic [3:0] be_val, cycle_drive_i, be_w, be_b_o, cycle_status_o;
  logic [4:0] addr_hi_o;
  logic [6:0] a10_i, a17_i, xd_i, rom_base_i, rom_mask_i, addr_10_16_o;
  logic [7:0] a2_i;
  int         bad_count, comparisons;

  lisas_far_side lisas_far_side_inst (.owner_i(owner), .be_val_i(be_val),
    .sbhe_val_i(sbhe_val), .xa_val_i(xa_val), .dev_be_i(be_b_o), .be_oe_b_i(be_oe_b_o),
    .dev_sbhe_i(sbhe_b_o), .sbhe_oe_b_i(sbhe_oe_b_o), .dev_xa_i(xa_o), .xa_oe_b_i(xa_oe_b_o),
    .hold_ack_o(hold_ack), .local_grant_b_o(grant_b), .isa_master_b_o(isam_b),
    .be_o(be_w), .sbhe_o(sbhe_w), .xa_o(xa_w));

  lisas_steering lisas_steering_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .hold_ack_i(hold_ack), .local_grant_b_i(grant_b), .isa_master_b_i(isam_b),
    .be_b_i(be_w), .be_b_o(be_b_o), .be_oe_b_o(be_oe_b_o), .sbhe_b_i(sbhe_w),
    .sbhe_b_o(sbhe_b_o), .sbhe_oe_b_o(sbhe_oe_b_o), .buffered_low_address_i(xa_w),
    .buffered_low_address_o(xa_o), .buffered_low_address_oe_b_o(xa_oe_b_o),
    .addr_2_9_i(a2_i), .addr_10_16_i(a10_i), .addr_10_16_o(addr_10_16_o),
    .addr_10_16_oe_b_o(a10_oe_b), .addr_17_23_i(a17_i), .addr_hi_o(addr_hi_o),
    .addr_hi_oe_b_o(hi_oe_b), .ads_b_i(ads_b_i), .m_io_i(m_io_i),
    .cycle_drive_i(cycle_drive_i), .cycle_status_o(cycle_status_o),
    .cycle_status_oe_b_o(status_oe_b), .intermediate_data_low_i(xd_i),
    .dma_load_i(dma_load_i), .rom_enable_i(rom_enable_i), .rom_base_i(rom_base_i),
    .rom_mask_i(rom_mask_i), .rom_or_kbc_select_b_o(sel_b),
    .local_device_claim_b_i(claim_b), .claim_enable_i(claim_enable_i),
    .claim_second_t2_i(claim_second_t2_i), .claimed_o(claimed_o),
    .claim_valid_o(claim_valid_o));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Inputs always change 1 ns after an edge, clear of the sampling instant.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic chkb(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chkb

  task automatic chkv(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chkv

  // Owner pins need two sync flops and one register before the enables move.
  task automatic set_owner(input logic [1:0] o);
    owner = o;
    cyc(4);
  endtask : set_owner

  task automatic summarize;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_host;
    logic [3:0] pats [0:5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3};
    set_owner(2'h0);
    chkb("be oe", 1'b1, be_oe_b_o);
    chkb("sbhe oe", 1'b0, sbhe_oe_b_o);
    chkb("xa oe", 1'b0, xa_oe_b_o);
    chkb("a10 oe", 1'b1, a10_oe_b);
    chkb("hi oe", 1'b1, hi_oe_b);
    chkb("status oe", 1'b1, status_oe_b);
    foreach (pats[i])
    begin
      be_val = pats[i];
      cyc(2);
      chkb("sbhe", pats[i][1] & pats[i][3], sbhe_b_o);
      chkb("xa1", pats[i][0] & pats[i][1], xa_o[1]);
      chkb("xa0", !(!pats[i][0] || (pats[i][1:0] == 2'h3 && !pats[i][2])), xa_o[0]);
    end
    $display("t_host done");
  endtask : t_host

  task automatic t_dma;
    logic [3:0] exp;
    set_owner(2'h1);
    chkb("be oe", 1'b0, be_oe_b_o);
    chkb("sbhe oe", 1'b1, sbhe_oe_b_o);
    chkb("xa oe", 1'b1, xa_oe_b_o);
    chkb("a10 oe", 1'b0, a10_oe_b);
    chkb("hi oe", 1'b0, hi_oe_b);
    chkv("hi", 8'h00, 8'(addr_hi_o));
    chkb("status oe", 1'b0, status_oe_b);
    cycle_drive_i = 4'hA;
    cyc(2);
    chkv("status", 8'h0A, 8'(cycle_status_o));
    // Two alternating patterns so every page latch bit toggles once.
    for (int k = 0; k < 2; k++)
    begin
      xd_i = (k == 0) ? 7'h2A : 7'h55;
      dma_load_i = 1'b1;
      cyc(1);
      dma_load_i = 1'b0;
      cyc(3);
      chkv("page", 8'(xd_i), 8'(addr_10_16_o));
    end
    for (int k = 0; k < 8; k++)
    begin
      xa_val = k[1:0];
      sbhe_val = k[2];
      cyc(4);
      exp = xa_val[1] ? {sbhe_val, xa_val[0], 2'h3} : {2'h3, sbhe_val, xa_val[0]};
      chkv("be", 8'(exp), 8'(be_b_o));
    end
    $display("t_dma done");
  endtask : t_dma

  task automatic t_isam;
    set_owner(2'h2);
    chkb("be oe", 1'b0, be_oe_b_o);
    chkb("a10 oe", 1'b1, a10_oe_b);
    chkb("hi oe", 1'b0, hi_oe_b);
    chkb("status oe", 1'b0, status_oe_b);
    set_owner(2'h0);
    chkb("hi oe", 1'b1, hi_oe_b);
    $display("t_isam done");
  endtask : t_isam

  task automatic t_select;
    logic [7:0] ports [0:3] = '{8'h18, 8'h19, 8'h1A, 8'h10};
    be_val = 4'hE;
    foreach (ports[i])
    begin
      a2_i = ports[i];
      cyc(4);
      chkb("kbc sel", !(i < 2), sel_b);
    end
    a2_i = 8'h18;
    m_io_i = 1'b1;
    cyc(4);
    chkb("kbc mem", 1'b1, sel_b);
    a17_i = 7'h7F;
    rom_base_i = 7'h7F;
    rom_mask_i = 7'h7F;
    rom_enable_i = 1'b1;
    cyc(4);
    chkb("rom sel", 1'b0, sel_b);
    rom_enable_i = 1'b0;
    cyc(4);
    chkb("rom off", 1'b1, sel_b);
    $display("t_select done");
  endtask : t_select

  // One strobe cycle; counts edges from the strobe to the sample pulse.
  task automatic claim_once(input logic second, input logic [7:0] exp_n,
                            input logic [2:0] exp_c);
    int n;
    claim_second_t2_i = second;
    ads_b_i = 1'b0;
    cyc(1);
    ads_b_i = 1'b1;
    n = 1;
    while (claim_valid_o !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    if (n >= 20)
    begin
      bad_count++;
      summarize();
    end
    chkv("claim delay", exp_n, 8'(n));
    chkv("claimed", 8'(exp_c), 8'(claimed_o));
    cyc(3);
  endtask : claim_once

  task automatic t_claim;
    claim_b = 3'h0;
    claim_once(1'b0, 8'h05, 3'h1);
    claim_enable_i = 2'h3;
    claim_once(1'b0, 8'h05, 3'h7);
    claim_b = 3'h5;
    claim_once(1'b1, 8'h06, 3'h2);
    claim_b = 3'h7;
    claim_once(1'b1, 8'h06, 3'h0);
    $display("t_claim done");
  endtask : t_claim

  // ---------------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------------
  // Free-running 100 MHz clock.
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Host owner from time zero so the pins are settled before reset lifts.
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    {rst_b_i, owner, dma_load_i, rom_enable_i, claim_second_t2_i, m_io_i} = '0;
    {ads_b_i, sbhe_val, be_val, claim_b} = '1;
    {xa_val, claim_enable_i, cycle_drive_i, a2_i} = '0;
    {a10_i, a17_i, xd_i, rom_base_i, rom_mask_i} = '0;
    repeat (6) @(posedge clock_i);
    chkb("reset be oe", 1'b1, be_oe_b_o);
    chkb("reset sel", 1'b1, sel_b);
    chkb("reset valid", 1'b0, claim_valid_o);
    #1 rst_b_i = 1'b1;
    cyc(4);
    t_host();
    t_select();
    t_claim();
    t_dma();
    t_isam();
    summarize();
  end

endmodule : lisas_steering_test
